// *** ost_consts.vh ***
`ifndef OST_CONSTS_VH
`define OST_CONSTS_VH

// ==========================================================================
// Tree select codes
// ==========================================================================
`define OST_SEL_OPER         2'h0
`define OST_SEL_SHUT         2'h1
`define OST_SEL_PROT         2'h2
`define OST_SEL_SHARE        2'h3

// ==========================================================================
// Host operation codes: op[2:1] is the field, op[0] set means a query
// ==========================================================================
`define OST_OP_EVT_QUERY     3'h0
`define OST_OP_COND_QUERY    3'h1
`define OST_OP_EN_WRITE      3'h2
`define OST_OP_EN_READ       3'h3
`define OST_OP_RISE_WRITE    3'h4
`define OST_OP_RISE_READ     3'h5
`define OST_OP_FALL_WRITE    3'h6
`define OST_OP_FALL_READ     3'h7
`define OST_FLD_NONE         2'h0
`define OST_FLD_ENABLE       2'h1
`define OST_FLD_RISE         2'h2
`define OST_FLD_FALL         2'h3

// ==========================================================================
// Reset values of the per-register structure
// ==========================================================================
`define OST_ENABLE_RST       16'h0000
`define OST_RISE_RST         16'hffff
`define OST_FALL_RST         16'h0000
`define OST_EVENT_RST        16'h0000
`define OST_COND_RST         16'h0000

// ==========================================================================
// Operation status bit positions
// ==========================================================================
`define OST_OPER_CAL_BIT     0
`define OST_OPER_SHUT_BIT    9
`define OST_OPER_LOCK_BIT    10
`define OST_OPER_SHARE_BIT   11
`define OST_OPER_CV_BIT      12
`define OST_OPER_CC_BIT      13
`define OST_OPER_PROG_BIT    14

// ==========================================================================
// Shutdown cause bit positions
// ==========================================================================
`define OST_SHUT_PROT_BIT    0
`define OST_SHUT_LOOP_BIT    1
`define OST_SHUT_EXT_BIT     3

// ==========================================================================
// Protection trip bit positions
// ==========================================================================
`define OST_PROT_OV_BIT      0
`define OST_PROT_UV_BIT      1
`define OST_PROT_OC_BIT      2
`define OST_PROT_AC_BIT      4
`define OST_PROT_OT_BIT      5
`define OST_PROT_FOLD_BIT    7
`define OST_PROT_FAN_BIT     8

// ==========================================================================
// Share role bit positions
// ==========================================================================
`define OST_SHARE_CTL_BIT    0
`define OST_SHARE_FOL_BIT    1

// ==========================================================================
// Positions of the raw inputs inside the synchroniser vector
// ==========================================================================
`define OST_PIN_CAL          0
`define OST_PIN_LOCK         1
`define OST_PIN_CV           2
`define OST_PIN_CC           3
`define OST_PIN_PROG         4
`define OST_PIN_LOOP         5
`define OST_PIN_EXT          6
`define OST_PIN_OV           7
`define OST_PIN_UV           8
`define OST_PIN_OC           9
`define OST_PIN_AC           10
`define OST_PIN_OT           11
`define OST_PIN_FOLD         12
`define OST_PIN_FAN          13
`define OST_PIN_SCTL         14
`define OST_PIN_SFOL         15

`endif

// *** ost_status_reg.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ost_consts.vh"

module ost_status_reg (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Live condition
    input  wire [15:0] cond_in,
    // Host writes and event read
    input  wire        wr_en,
    input  wire [1:0]  wr_field,
    input  wire [15:0] wr_data,
    input  wire        evt_clr,
    // Stored state and the summary derived from it
    output reg  [15:0] event_reg,
    output reg  [15:0] enable_reg,
    output reg  [15:0] rise_reg,
    output reg  [15:0] fall_reg,
    output wire        summary
);

    // ======================================================================
    // Edge detection and event latching
    // ======================================================================
    reg  [15:0] cond_prev_reg;
    wire [15:0] edge_hit;
    wire [15:0] event_next;

    // Rising edges pass the rising filter, falling edges the falling one
    assign edge_hit = (cond_in & ~cond_prev_reg & rise_reg)
                    | (~cond_in & cond_prev_reg & fall_reg);        // R20
    // A new edge in the clearing cycle survives the clear
    assign event_next = (evt_clr ? 16'h0000 : event_reg) | edge_hit; // R21

    // Summary is the enabled events ORed together
    assign summary = |(event_reg & enable_reg);                     // R2 R21

    // State update; filters and enable only change on host writes
    always @(posedge sys_clk) begin
        if (rst) begin
            cond_prev_reg <= `OST_COND_RST;
            event_reg     <= `OST_EVENT_RST;
            enable_reg    <= `OST_ENABLE_RST;
            rise_reg      <= `OST_RISE_RST;
            fall_reg      <= `OST_FALL_RST;
        end else begin
            cond_prev_reg <= cond_in;
            event_reg     <= event_next;
            if (wr_en && wr_field == `OST_FLD_ENABLE) begin
                enable_reg <= wr_data;                               // R18
            end
            if (wr_en && wr_field == `OST_FLD_RISE) begin
                rise_reg <= wr_data;                                 // R18
            end
            if (wr_en && wr_field == `OST_FLD_FALL) begin
                fall_reg <= wr_data;                                 // R18
            end
        end
    end

endmodule
`default_nettype wire

// *** ost_top.v ***
// Function
// R1: Every tree register is sixteen bits and yields one summary bit upward.
// R2: Summary output is the OR of the register's reportable bits.
// R3: Operation bit 0 is high while the supply is calibration_active.
// R4: Operation bit 9 carries the shutdown-cause summary.
// R5: Operation bit 11 carries the share-role summary.
// R6: Operation bits 12 and 13 show constant-voltage and constant-current regulation.
// R7: Operation bit 14 is high while a stored sequence program runs.
// R8: Shutdown causes may be active together, each independent.
// R9: Shutdown bit 0 carries the protection-trip summary.
// R10: Shutdown bit 1 shows shutoff by the safety loop input.
// R11: Shutdown bit 3 shows external shutdown; bit 2 unused.
// R12: Protection bits 0, 1, 2 show overvoltage, undervoltage, overcurrent trips.
// R13: Protection bits 4 and 5 show mains failure and overtemperature; bit 3 unused.
// R14: Protection bits 7 and 8 show foldback and fan failure; bit 6 unused.
// R15: Share bits 0 and 1 show controller and follower role.
// R16: Host keeps the controller role whenever sharing is unused.
// R17: Every query result is returned as a decimal number.
// R18: Each register supports event, condition, enable and both filter accesses.
// R19: Standard event register and status byte lie outside this structure.
// R20: Filtered condition edges latch the matching event bit.
// R21: Reading events clears them; summary is OR of enabled events.
`timescale 1ns/1ps
`default_nettype none
`include "ost_consts.vh"

module ost_top (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Operating state inputs, asynchronous to sys_clk
    input  wire        calibration_active,
    input  wire        local_lockout,
    input  wire        cv_mode,
    input  wire        cc_mode,
    input  wire        program_running,
    // Shutdown source inputs, asynchronous
    input  wire        safety_loop_input,
    input  wire        ext_shutdown,
    // Protection trip inputs, asynchronous
    input  wire        overvoltage_trip,
    input  wire        undervoltage_trip,
    input  wire        overcurrent_trip,
    input  wire        mains_fail_trip,
    input  wire        overtemp_trip,
    input  wire        foldback_trip,
    input  wire        fan_fail_trip,
    // Share role inputs, asynchronous
    input  wire        share_controller,
    input  wire        share_follower,
    // Host command port
    input  wire        cmd_valid,
    input  wire [1:0]  cmd_sel,
    input  wire [2:0]  cmd_op,
    input  wire [15:0] cmd_data,
    // Host answer port
    output reg         resp_valid,
    output reg  [19:0] resp_dec,
    output reg  [15:0] resp_bin,
    // Summary toward the status byte
    output wire        oper_summary
);

    // ======================================================================
    // Helper functions
    // ======================================================================

    // Binary to five BCD digits by shift and add three
    function [19:0] ost_to_dec;
        input [15:0] value;
        reg   [35:0] work;
        integer      i;
        begin
            work = {20'h00000, value};
            for (i = 0; i < 16; i = i + 1) begin
                if (work[19:16] > 4'h4) work[19:16] = work[19:16] + 4'h3;
                if (work[23:20] > 4'h4) work[23:20] = work[23:20] + 4'h3;
                if (work[27:24] > 4'h4) work[27:24] = work[27:24] + 4'h3;
                if (work[31:28] > 4'h4) work[31:28] = work[31:28] + 4'h3;
                if (work[35:32] > 4'h4) work[35:32] = work[35:32] + 4'h3;
                work = {work[34:0], 1'b0};
            end
            ost_to_dec = work[35:16];
        end
    endfunction

    // Field addressed by an operation code
    function [1:0] ost_field;
        input [2:0] op;
        begin
            ost_field = op[2:1];
        end
    endfunction

    // Operation codes that store host data
    function ost_is_write;
        input [2:0] op;
        begin
            ost_is_write = !op[0] && (op[2:1] != `OST_FLD_NONE);
        end
    endfunction

    // ======================================================================
    // Input synchronisers
    // ======================================================================
    wire [15:0] pin_raw;
    reg  [15:0] pin_meta_reg;
    reg  [15:0] pin_sync_reg;

    assign pin_raw = {share_follower, share_controller, fan_fail_trip,
                      foldback_trip, overtemp_trip, mains_fail_trip,
                      overcurrent_trip, undervoltage_trip, overvoltage_trip,
                      ext_shutdown, safety_loop_input, program_running,
                      cc_mode, cv_mode, local_lockout, calibration_active};

    // Two stages; only the second stage feeds the tree
    always @(posedge sys_clk) begin
        if (rst) begin
            pin_meta_reg <= 16'h0000;
            pin_sync_reg <= 16'h0000;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ======================================================================
    // Condition vectors of the four registers
    // ======================================================================
    reg  [15:0] oper_cond;
    reg  [15:0] shut_cond;
    reg  [15:0] prot_cond;
    reg  [15:0] share_cond;
    wire [3:0]  summary_all;
    wire [63:0] cond_all;

    // Protection trips; bits 3, 6 and 9 to 15 stay zero
    always @* begin
        prot_cond = 16'h0000;
        prot_cond[`OST_PROT_OV_BIT]   = pin_sync_reg[`OST_PIN_OV];   // R12
        prot_cond[`OST_PROT_UV_BIT]   = pin_sync_reg[`OST_PIN_UV];   // R12
        prot_cond[`OST_PROT_OC_BIT]   = pin_sync_reg[`OST_PIN_OC];   // R12
        prot_cond[`OST_PROT_AC_BIT]   = pin_sync_reg[`OST_PIN_AC];   // R13
        prot_cond[`OST_PROT_OT_BIT]   = pin_sync_reg[`OST_PIN_OT];   // R13
        prot_cond[`OST_PROT_FOLD_BIT] = pin_sync_reg[`OST_PIN_FOLD]; // R14
        prot_cond[`OST_PROT_FAN_BIT]  = pin_sync_reg[`OST_PIN_FAN];  // R14
    end

    // Shutdown causes are separate bits, so several may stand together
    always @* begin
        shut_cond = 16'h0000;                                          // R8
        shut_cond[`OST_SHUT_PROT_BIT] = summary_all[`OST_SEL_PROT];    // R9
        shut_cond[`OST_SHUT_LOOP_BIT] = pin_sync_reg[`OST_PIN_LOOP];   // R10
        shut_cond[`OST_SHUT_EXT_BIT]  = pin_sync_reg[`OST_PIN_EXT];    // R11
    end

    // Share role; the controller default when sharing is off is up to the host
    always @* begin
        share_cond = 16'h0000;
        share_cond[`OST_SHARE_CTL_BIT] = pin_sync_reg[`OST_PIN_SCTL];  // R15
        share_cond[`OST_SHARE_FOL_BIT] = pin_sync_reg[`OST_PIN_SFOL];  // R15
    end

    // Top register; unimplemented bits read zero
    always @* begin
        oper_cond = 16'h0000;
        oper_cond[`OST_OPER_CAL_BIT]   = pin_sync_reg[`OST_PIN_CAL];    // R3
        oper_cond[`OST_OPER_SHUT_BIT]  = summary_all[`OST_SEL_SHUT];    // R4
        oper_cond[`OST_OPER_LOCK_BIT]  = pin_sync_reg[`OST_PIN_LOCK];
        oper_cond[`OST_OPER_SHARE_BIT] = summary_all[`OST_SEL_SHARE];   // R5
        oper_cond[`OST_OPER_CV_BIT]    = pin_sync_reg[`OST_PIN_CV];     // R6
        oper_cond[`OST_OPER_CC_BIT]    = pin_sync_reg[`OST_PIN_CC];     // R6
        oper_cond[`OST_OPER_PROG_BIT]  = pin_sync_reg[`OST_PIN_PROG];   // R7
    end

    // Flat vector indexed by select code
    assign cond_all = {share_cond, prot_cond, shut_cond, oper_cond};

    // ======================================================================
    // Register instances; each summary feeds the level above
    // ======================================================================
    wire [63:0] event_all;
    wire [63:0] enable_all;
    wire [63:0] rise_all;
    wire [63:0] fall_all;

    // Summaries pass up one register per cycle, a trip shows at the top late
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_reg
            wire hit;
            assign hit = cmd_valid && (cmd_sel == g[1:0]);
            ost_status_reg u_reg (
                .sys_clk    (sys_clk),
                .rst        (rst),
                .cond_in    (cond_all[16*g +: 16]),
                .wr_en      (hit && ost_is_write(cmd_op)),
                .wr_field   (ost_field(cmd_op)),
                .wr_data    (cmd_data),
                .evt_clr    (hit && cmd_op == `OST_OP_EVT_QUERY),     // R21
                .event_reg  (event_all[16*g +: 16]),
                .enable_reg (enable_all[16*g +: 16]),
                .rise_reg   (rise_all[16*g +: 16]),
                .fall_reg   (fall_all[16*g +: 16]),
                .summary    (summary_all[g])                            // R1
            );
        end
    endgenerate

    // Summary toward the status byte, which is kept elsewhere
    assign oper_summary = summary_all[`OST_SEL_OPER];                   // R19

    // ======================================================================
    // Query path
    // ======================================================================
    reg [15:0] query_value;
    reg        query_hit;

    // Pick the addressed field; event read shows the value before clearing
    always @* begin
        query_hit   = cmd_valid && cmd_op[0];
        query_value = 16'h0000;
        case (cmd_op)
            `OST_OP_EVT_QUERY: begin
                query_hit   = cmd_valid;
                query_value = event_all[16*cmd_sel +: 16];              // R18
            end
            `OST_OP_COND_QUERY: begin
                query_value = cond_all[16*cmd_sel +: 16];               // R18
            end
            `OST_OP_EN_READ: begin
                query_value = enable_all[16*cmd_sel +: 16];             // R18
            end
            `OST_OP_RISE_READ: begin
                query_value = rise_all[16*cmd_sel +: 16];               // R18
            end
            `OST_OP_FALL_READ: begin
                query_value = fall_all[16*cmd_sel +: 16];               // R18
            end
            default: begin
                query_value = 16'h0000;
            end
        endcase
    end

    // Answer one cycle after the query, in decimal digits
    always @(posedge sys_clk) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_dec   <= 20'h00000;
            resp_bin   <= 16'h0000;
        end else begin
            resp_valid <= query_hit;
            if (query_hit) begin
                resp_dec <= ost_to_dec(query_value);                    // R17
                resp_bin <= query_value;
            end
        end
    end

endmodule
`default_nettype wire

// *** ost_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ost_consts.vh"
// ==========================================================================
// Port checks of the status tree
module ost_top_assertions (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Status inputs
    input wire logic        calibration_active,
    input wire logic        cv_mode,
    input wire logic        cc_mode,
    input wire logic        program_running,
    input wire logic        safety_loop_input,
    input wire logic        ext_shutdown,
    input wire logic        overvoltage_trip,
    input wire logic        undervoltage_trip,
    input wire logic        overcurrent_trip,
    input wire logic        mains_fail_trip,
    input wire logic        overtemp_trip,
    input wire logic        foldback_trip,
    input wire logic        fan_fail_trip,
    input wire logic        share_controller,
    input wire logic        share_follower,
    // Host port
    input wire logic        cmd_valid,
    input wire logic [1:0]  cmd_sel,
    input wire logic [2:0]  cmd_op,
    input wire logic [15:0] cmd_data,
    input wire logic        resp_valid,
    input wire logic [19:0] resp_dec,
    input wire logic [15:0] resp_bin,
    input wire logic        oper_summary
);
    // Pins gathered in synchroniser order
    wire [15:0] pv = {share_follower, share_controller, fan_fail_trip, foldback_trip,
        overtemp_trip, mains_fail_trip, overcurrent_trip, undervoltage_trip,
        overvoltage_trip, ext_shutdown, safety_loop_input, program_running,
        cc_mode, cv_mode, 1'b0, calibration_active};
    wire [15:0] prot_map = {7'h00, pv[13:12], 1'b0, pv[11:10], 1'b0, pv[9:7]};
    wire [15:0] share_map = {14'h0000, pv[15:14]};
    reg  [15:0] h1_reg, h2_reg, h3_reg, h4_reg;
    // A pin counts once stable for five samples
    wire [15:0] st = (pv & h1_reg & h2_reg & h3_reg & h4_reg)
                   | ~(pv | h1_reg | h2_reg | h3_reg | h4_reg);
    wire        is_q = cmd_valid && (cmd_op[0] || cmd_op == `OST_OP_EVT_QUERY);
    wire        q_cond = cmd_valid && cmd_op == `OST_OP_COND_QUERY;
    wire [31:0] dec_val = resp_dec[19:16] * 32'd10000 + resp_dec[15:12] * 32'd1000
                        + resp_dec[11:8] * 32'd100 + resp_dec[7:4] * 32'd10 + resp_dec[3:0];
    wire        digits_ok = resp_dec[19:16] < 10 && resp_dec[15:12] < 10
                        && resp_dec[11:8] < 10 && resp_dec[7:4] < 10 && resp_dec[3:0] < 10;

    // Pin history
    always @(posedge sys_clk) begin
        if (rst) begin
            {h1_reg, h2_reg, h3_reg, h4_reg} <= 64'h0;
        end else begin
            {h1_reg, h2_reg, h3_reg, h4_reg} <= {pv, h1_reg, h2_reg, h3_reg};
        end
    end

    default clocking dck @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_query_answer: assert property (is_q |=> resp_valid)
        else $error("query not answered");
    a_write_silent: assert property (cmd_valid && !is_q |=> !resp_valid)
        else $error("write gave an answer");
    a_dec_equal: assert property (resp_valid |-> digits_ok && dec_val == {16'h0, resp_bin})
        else $error("bad decimal");
    a_enable_mask: assert property (cmd_valid && cmd_sel == `OST_SEL_OPER
        && cmd_op == `OST_OP_EN_WRITE && cmd_data == 0 |=> !oper_summary)
        else $error("summary with enable cleared");
    a_cal_cond: assert property (q_cond && cmd_sel == `OST_SEL_OPER && st[0]
        |=> resp_bin[0] == $past(calibration_active)) else $error("calibration bit wrong");
    a_mode_cond: assert property (q_cond && cmd_sel == `OST_SEL_OPER && (&st[4:2])
        |=> resp_bin[14:12] == $past(pv[4:2])) else $error("mode bits wrong");
    a_shut_causes: assert property (q_cond && cmd_sel == `OST_SEL_SHUT && (&st[6:5])
        |=> resp_bin[3:1] == {$past(ext_shutdown), 1'b0, $past(safety_loop_input)})
        else $error("shutdown cause bits wrong");
    a_prot_trips: assert property (q_cond && cmd_sel == `OST_SEL_PROT
        && (&st[13:7]) |=> resp_bin == $past(prot_map)) else $error("trip bits wrong");
    a_share_roles: assert property (q_cond && cmd_sel == `OST_SEL_SHARE
        && (&st[15:14]) |=> resp_bin == $past(share_map)) else $error("share role bits wrong");
endmodule

bind ost_top ost_top_assertions chk (.sys_clk(sys_clk), .rst(rst),
    .calibration_active(calibration_active),
    .cv_mode(cv_mode), .cc_mode(cc_mode), .program_running(program_running),
    .safety_loop_input(safety_loop_input), .ext_shutdown(ext_shutdown),
    .overvoltage_trip(overvoltage_trip), .undervoltage_trip(undervoltage_trip),
    .overcurrent_trip(overcurrent_trip), .mains_fail_trip(mains_fail_trip),
    .overtemp_trip(overtemp_trip), .foldback_trip(foldback_trip),
    .fan_fail_trip(fan_fail_trip), .share_controller(share_controller),
    .share_follower(share_follower), .cmd_valid(cmd_valid), .cmd_sel(cmd_sel),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .resp_valid(resp_valid),
    .resp_dec(resp_dec), .resp_bin(resp_bin), .oper_summary(oper_summary));
`default_nettype wire

// *** ost_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Remote host issuing status commands
module ost_host_model (
    // Clock
    input wire logic        sys_clk,
    // Command side
    output var logic        cmd_valid,
    output var logic [1:0]  cmd_sel,
    output var logic [2:0]  cmd_op,
    output var logic [15:0] cmd_data,
    // Answer side
    input wire logic        resp_valid,
    input wire logic [19:0] resp_dec,
    input wire logic [15:0] resp_bin
);
    logic        ans_valid;
    logic [19:0] ans_dec;
    logic [15:0] ans_bin;

    // Idle port at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_sel = 2'h0;
        cmd_op = 3'h0;
        cmd_data = 16'h0000;
    end

    // One command; the answer is read while it stands
    task do_cmd(input logic [1:0] sel, input logic [2:0] op, input logic [15:0] data);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_sel <= sel;
        cmd_op <= op;
        cmd_data <= data;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        cmd_data <= ~data; // Old data not left showing
        #1;
        ans_valid = resp_valid;
        ans_dec = resp_dec;
        ans_bin = resp_bin;
    endtask
endmodule
`default_nettype wire

// *** test_ost_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ost_consts.vh"
// ==========================================================================
// Status tree testbench
module test_ost_top;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] pins;
    wire         cmd_valid, resp_valid, oper_summary;
    wire [1:0]   cmd_sel;
    wire [2:0]   cmd_op;
    wire [15:0]  cmd_data, resp_bin;
    wire [19:0]  resp_dec;
    int          bad_count = 0;
    int          checks_done = 0;
    logic [1:0]  exp_sel [16] = '{0, 0, 0, 0, 0, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3};
    int          exp_bit [16] = '{0, 10, 12, 13, 14, 1, 3, 0, 1, 2, 4, 5, 7, 8, 0, 1};
    localparam logic [15:0] CTL = 16'h0001 << `OST_PIN_SCTL;
    localparam logic [15:0] OV = 16'h0001 << `OST_PIN_OV;

    always #2.5 sys_clk = ~sys_clk;

    ost_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_sel(cmd_sel),
        .cmd_op(cmd_op), .cmd_data(cmd_data), .resp_valid(resp_valid),
        .resp_dec(resp_dec), .resp_bin(resp_bin));
    ost_top uut (.sys_clk(sys_clk), .rst(rst), .calibration_active(pins[0]),
        .local_lockout(pins[1]), .cv_mode(pins[2]), .cc_mode(pins[3]),
        .program_running(pins[4]), .safety_loop_input(pins[5]), .ext_shutdown(pins[6]),
        .overvoltage_trip(pins[7]), .undervoltage_trip(pins[8]),
        .overcurrent_trip(pins[9]), .mains_fail_trip(pins[10]), .overtemp_trip(pins[11]),
        .foldback_trip(pins[12]), .fan_fail_trip(pins[13]), .share_controller(pins[14]),
        .share_follower(pins[15]), .cmd_valid(cmd_valid), .cmd_sel(cmd_sel),
        .cmd_op(cmd_op), .cmd_data(cmd_data), .resp_valid(resp_valid),
        .resp_dec(resp_dec), .resp_bin(resp_bin), .oper_summary(oper_summary));

    task check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Expected decimal digits
    function logic [19:0] bcd(input logic [15:0] v);
        int i;
        logic [19:0] r;
        r = 20'h0;
        for (i = 0; i < 5; i++) begin
            r[i*4 +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return r;
    endfunction

    task ask(input string name, input logic [1:0] sel, input logic [2:0] op,
             input logic [15:0] exp);
        host.do_cmd(sel, op, 16'h0000);
        check(name, {19'h0, host.ans_valid}, 20'h1);
        check(name, {4'h0, host.ans_bin}, {4'h0, exp});
        check(name, host.ans_dec, bcd(exp));
    endtask

    // Pins change on an edge; the tree then settles
    task set_pins(input logic [15:0] v);
        @(posedge sys_clk) pins <= v;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask

    task clear_all;
        logic [2:0] s;
        for (s = 0; s < 4; s++) host.do_cmd(s[1:0], `OST_OP_EVT_QUERY, 16'h0000);
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog well past the sequence length
    initial begin
        #100000;
        bad_count++;
        close_out;
    end

    // Main sequence
    initial begin
        logic [2:0] s;
        int k;
        pins = CTL;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        set_pins(CTL);
        for (s = 0; s < 4; s++) begin
            ask("enable", s[1:0], `OST_OP_EN_READ, 16'h0000);
            ask("rise", s[1:0], `OST_OP_RISE_READ, 16'hffff);
            ask("fall", s[1:0], `OST_OP_FALL_READ, 16'h0000);
            host.do_cmd(s[1:0], `OST_OP_EN_WRITE, 16'hffff);
            ask("enable rw", s[1:0], `OST_OP_EN_READ, 16'hffff);
            host.do_cmd(s[1:0], `OST_OP_EN_WRITE, 16'h0000);
        end
        // Each pin, with the controller role pin held high, lights its own condition bit
        for (k = 0; k < 16; k++) begin
            set_pins((16'h0001 << k) | CTL);
            ask("condition", exp_sel[k], `OST_OP_COND_QUERY,
                (16'h0001 << exp_bit[k]) | 16'(exp_sel[k] == 3));
        end
        set_pins(CTL);
        clear_all;
        // A trip climbs the tree to the top summary
        host.do_cmd(2, `OST_OP_EN_WRITE, 16'h0001);
        host.do_cmd(1, `OST_OP_EN_WRITE, 16'h0001);
        host.do_cmd(0, `OST_OP_EN_WRITE, 16'h0200);
        set_pins(CTL | OV);
        check("summary", {19'h0, oper_summary}, 20'h1);
        ask("prot event", 2, `OST_OP_EVT_QUERY, 16'h0001);
        ask("shut event", 1, `OST_OP_EVT_QUERY, 16'h0001);
        ask("oper event", 0, `OST_OP_EVT_QUERY, 16'h0200);
        ask("oper cleared", 0, `OST_OP_EVT_QUERY, 16'h0000);
        // Falling edges only
        host.do_cmd(2, `OST_OP_RISE_WRITE, 16'h0000);
        host.do_cmd(2, `OST_OP_FALL_WRITE, 16'hffff);
        ask("fall rw", 2, `OST_OP_FALL_READ, 16'hffff);
        set_pins(CTL | OV | (16'h0001 << `OST_PIN_UV));
        ask("rise blocked", 2, `OST_OP_EVT_QUERY, 16'h0000);
        set_pins(CTL);
        ask("fall event", 2, `OST_OP_EVT_QUERY, 16'h0003);
        set_pins(CTL | (16'h0001 << `OST_PIN_LOOP) | (16'h0001 << `OST_PIN_EXT));
        ask("causes", 1, `OST_OP_COND_QUERY, 16'h000a);
        clear_all;
        host.do_cmd(3, `OST_OP_EN_WRITE, 16'h0002);
        set_pins(CTL | (16'h0001 << `OST_PIN_SFOL));
        ask("share summary", 0, `OST_OP_COND_QUERY, 16'h0800);
        close_out;
    end
endmodule
`default_nettype wire
